// ===== design/ops_clk_ctrl.v
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "ops_defines.vh"

// Contract
// - range code 100..111 picks oscillator mode
// - oscillator wake count 258, 1K or 16K
// - oscillator reset delay 14 plus 0/short/long
// - external clock wakes 6, reset 14+0/4/64ms
// - loop runs only while enable bit set
// - lock flag set once loop locked
// - loop chosen by config: factor starts 6
// - loop reference from RC, crystal, clock
// - deep sleep stops RC oscillator and loop
// - loop source start-up 1K/16K, reset delays
// - clock out when option or bit set
// - no clock out in reset; overrides pin
// - divided system clock goes to pin
// - start-up counted on selected source cycles
// - reset delay counts 512 or 8192 watchdog
module ops_clk_ctrl #(
  parameter [13:0] WDT_LONG = `OPS_WDT_LONG,  // long reset delay
  parameter [14:0] CNT_16K  = `OPS_CNT_16KCK  // long start-up count
) (
  input  wire       clk,                 // system clock
  input  wire       rst,                 // async reset, high
  input  wire       ce,                  // clock enable
  input  wire [3:0] addr,                // register address
  input  wire [7:0] wdata,               // write data
  input  wire       wr,                  // write strobe
  input  wire       rd,                  // read strobe
  output reg  [7:0] rdata,               // read data, next cycle
  input  wire [3:0] nv_source_select,    // non-volatile source
  input  wire [1:0] nv_startup_code,     // non-volatile start-up
  input  wire       nv_clock_out_option, // non-volatile clock out
  input  wire       src_tick,            // selected source cycle
  input  wire       wdt_tick,            // watchdog osc cycle
  input  wire       sleep_deep,          // power-down/standby
  input  wire       loop_lock_in,        // analog lock detect
  input  wire       presc_clk_in,        // prescaled system clock
  output reg        cpu_run,             // execution allowed
  output reg        rc_osc_run,          // internal RC enable
  output reg        loop_run,            // multiplying loop run
  output reg  [1:0] loop_ref_sel,        // loop reference select
  output reg  [3:0] loop_factor,         // loop multiplication
  output reg        osc_amp_en,          // crystal amplifier on
  output reg  [2:0] osc_range_code,      // amplifier mode
  output reg        clock_output_pin,    // clock out level
  output reg        clock_output_oe,     // clock out drive/override
  output wire       irq                  // level interrupt
);

  // --------------------------------------------------------------------
  // state encoding
  // --------------------------------------------------------------------
  localparam [5:0] ST_LATCH = 6'b00_0001; // capture config
  localparam [5:0] ST_RSTCK = 6'b00_0010; // 14 source cycles
  localparam [5:0] ST_RSTWD = 6'b00_0100; // watchdog delay
  localparam [5:0] ST_RUN   = 6'b00_1000; // running
  localparam [5:0] ST_SLEEP = 6'b01_0000; // deep sleep
  localparam [5:0] ST_WAKE  = 6'b10_0000; // wake start-up

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg  [5:0]  st_q, st_d;       // sequencer state
  reg  [3:0]  src_q;            // source select
  reg  [1:0]  sut_q;            // startup_time_code
  reg         clock_out_enable_bit_q;           // clock_out_enable_bit
  reg         nvco_q;           // latched nv_clock_out_option
  reg         lp_en_q;          // loop_enable_bit
  reg  [1:0]  lp_ref_q;         // loop reference field
  reg  [3:0]  mul_q;            // multiplication factor
  reg         lock_q;           // loop_lock_flag
  reg  [3:0]  stat_q;           // sticky events
  reg  [3:0]  mask_q;           // event mask
  reg  [3:0]  ev;               // events this cycle
  reg  [14:0] wake_cnt;         // start-up count for selection
  reg  [13:0] wdt_cnt;          // reset delay in watchdog cycles
  reg         sc_start;         // start source counter
  reg         wc_start;         // start watchdog counter
  wire        sc_done;          // source count over
  wire        wc_done;          // watchdog count over
  wire        is_osc;           // crystal oscillator selected
  wire        is_loop;          // loop drives system clock
  wire        nv_is_loop;       // config picks loop
  wire        lock_now;         // qualified lock

  assign is_osc     = src_q[3];
  assign is_loop    = (src_q == `OPS_SRC_LOOP_RC) ||
                      (src_q == `OPS_SRC_LOOP_XT) ||
                      (src_q == `OPS_SRC_LOOP_EC);
  assign nv_is_loop = (nv_source_select == `OPS_SRC_LOOP_RC) ||
                      (nv_source_select == `OPS_SRC_LOOP_XT) ||
                      (nv_source_select == `OPS_SRC_LOOP_EC);
  assign lock_now   = loop_lock_in & lp_en_q & ~st_q[4];

  // --------------------------------------------------------------------
  // start-up count and reset delay tables
  // --------------------------------------------------------------------
  // wake count per selection; reset delay in watchdog cycles
  always @* begin
    wake_cnt = `OPS_CNT_6CK;
    wdt_cnt  = `OPS_WDT_NONE;
    if (is_osc) begin
      case ({src_q[0], sut_q})
        3'b000: begin
          wake_cnt = `OPS_CNT_258CK;
          wdt_cnt  = `OPS_WDT_SHORT;
        end
        3'b001: begin
          wake_cnt = `OPS_CNT_258CK;
          wdt_cnt  = WDT_LONG;
        end
        3'b010: wake_cnt = `OPS_CNT_1KCK;
        3'b011: begin
          wake_cnt = `OPS_CNT_1KCK;
          wdt_cnt  = `OPS_WDT_SHORT;
        end
        3'b100: begin
          wake_cnt = `OPS_CNT_1KCK;
          wdt_cnt  = WDT_LONG;
        end
        3'b101: wake_cnt = CNT_16K;
        3'b110: begin
          wake_cnt = CNT_16K;
          wdt_cnt  = `OPS_WDT_SHORT;
        end
        default: begin
          wake_cnt = CNT_16K;
          wdt_cnt  = WDT_LONG;
        end
      endcase
    end else if (src_q == `OPS_SRC_LOOP_EC) begin
      wake_cnt = CNT_16K;
      case (sut_q)
        2'b00:   wdt_cnt = `OPS_WDT_NONE;
        2'b11:   wdt_cnt = WDT_LONG;
        default: wdt_cnt = `OPS_WDT_SHORT;
      endcase
    end else if (src_q == `OPS_SRC_LOOP_XT && sut_q == 2'b11) begin
      wake_cnt = CNT_16K;
    end else begin
      // external clock, RC, watchdog osc, loop on RC/crystal
      if (is_loop)
        wake_cnt = `OPS_CNT_1KCK;
      else
        wake_cnt = `OPS_CNT_6CK;
      case (sut_q)
        2'b00:   wdt_cnt = `OPS_WDT_NONE;
        2'b01:   wdt_cnt = `OPS_WDT_SHORT;
        default: wdt_cnt = WDT_LONG; // reserved 11 taken as longest
      endcase
    end
  end

  // --------------------------------------------------------------------
  // counters: source cycles and watchdog cycles
  // --------------------------------------------------------------------
  ops_tick_counter #(.W(15)) u_src_cnt (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .start  (sc_start),
    .tick   (src_tick),
    .target (st_q[0] ? `OPS_CNT_RST_CK : wake_cnt),
    .busy   (),
    .done   (sc_done)
  );

  ops_tick_counter #(.W(14)) u_wdt_cnt (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .start  (wc_start),
    .tick   (wdt_tick),
    .target (wdt_cnt),
    .busy   (),
    .done   (wc_done)
  );

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  // next state, counter starts and completion events
  always @* begin
    st_d     = st_q;
    sc_start = 1'b0;
    wc_start = 1'b0;
    ev       = 4'h0;
    case (st_q)
      ST_LATCH: begin
        st_d     = ST_RSTCK;
        sc_start = 1'b1;
      end
      ST_RSTCK: begin
        if (sc_done) begin
          if (wdt_cnt == `OPS_WDT_NONE) begin
            st_d = ST_RUN;
            ev[`OPS_ST_RSTDONE] = 1'b1;
          end else begin
            st_d     = ST_RSTWD;
            wc_start = 1'b1;
          end
        end
      end
      ST_RSTWD: begin
        if (wc_done) begin
          st_d = ST_RUN;
          ev[`OPS_ST_RSTDONE] = 1'b1;
        end
      end
      ST_RUN: begin
        if (sleep_deep)
          st_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!sleep_deep) begin
          st_d     = ST_WAKE;
          sc_start = 1'b1;
        end
      end
      ST_WAKE: begin
        if (sc_done) begin
          st_d = ST_RUN;
          ev[`OPS_ST_WAKEDONE] = 1'b1;
        end
      end
      default: st_d = ST_LATCH;
    endcase
    ev[`OPS_ST_LOCKUP]   = lock_now & ~lock_q;
    ev[`OPS_ST_LOCKLOST] = ~lock_now & lock_q;
  end

  // state register
  always @(posedge clk or posedge rst) begin
    if (rst)
      st_q <= ST_LATCH;
    else if (ce)
      st_q <= st_d;
  end

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  // selection and loop registers, config capture after reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q    <= 4'h0;
      sut_q    <= 2'h0;
      clock_out_enable_bit_q   <= 1'b0;
      nvco_q   <= 1'b0;
      lp_en_q  <= 1'b0;
      lp_ref_q <= `OPS_REF_RC;
      mul_q    <= `OPS_MUL_RST;
      mask_q   <= 4'h0;
    end else if (ce) begin
      if (st_q[0]) begin
        src_q  <= nv_source_select;
        sut_q  <= nv_startup_code;
        clock_out_enable_bit_q <= nv_clock_out_option;
        nvco_q <= nv_clock_out_option;
        if (nv_is_loop) begin
          mul_q   <= `OPS_MUL_INIT;
          lp_en_q <= 1'b1;
          case (nv_source_select)
            `OPS_SRC_LOOP_XT: lp_ref_q <= `OPS_REF_XTAL;
            `OPS_SRC_LOOP_EC: lp_ref_q <= `OPS_REF_EXTCLK;
            default:          lp_ref_q <= `OPS_REF_RC;
          endcase
        end
      end else if (wr) begin
        case (addr)
          `OPS_ADDR_CSR: begin
            src_q  <= wdata[`OPS_CSR_SRC_MSB:`OPS_CSR_SRC_LSB];
            sut_q  <= wdata[`OPS_CSR_SUT_MSB:`OPS_CSR_SUT_LSB];
            clock_out_enable_bit_q <= wdata[`OPS_CSR_CLOCK_OUT_ENABLE_BIT];
          end
          `OPS_ADDR_LCR: begin
            lp_en_q  <= wdata[`OPS_LCR_EN];
            // only the three reference sources are taken
            if (wdata[`OPS_LCR_REF_MSB:`OPS_LCR_REF_LSB] != 2'h3)
              lp_ref_q <= wdata[`OPS_LCR_REF_MSB:`OPS_LCR_REF_LSB];
          end
          `OPS_ADDR_MUL:  mul_q  <= wdata[3:0];
          `OPS_ADDR_MASK: mask_q <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // sticky status: hardware set wins over write-one clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= 4'h0;
      lock_q <= 1'b0;
    end else if (ce) begin
      lock_q <= lock_now;
      if (wr && addr == `OPS_ADDR_STAT)
        stat_q <= (stat_q & ~wdata[3:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

  // read data, valid the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `OPS_ADDR_CSR:   rdata <= {1'b0, clock_out_enable_bit_q, sut_q, src_q};
          `OPS_ADDR_LCR:   rdata <= {4'h0, lp_ref_q, lp_en_q, lock_q};
          `OPS_ADDR_MUL:   rdata <= {4'h0, mul_q};
          `OPS_ADDR_STAT:  rdata <= {4'h0, stat_q};
          `OPS_ADDR_MASK:  rdata <= {4'h0, mask_q};
          `OPS_ADDR_STATE: rdata <= {2'h0, st_q};
          default:         rdata <= 8'h00;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // clock source enables and clock output
  // --------------------------------------------------------------------
  // registered enables; deep sleep stops RC and loop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_run          <= 1'b0;
      rc_osc_run       <= 1'b0;
      loop_run         <= 1'b0;
      loop_ref_sel     <= `OPS_REF_RC;
      loop_factor      <= `OPS_MUL_RST;
      osc_amp_en       <= 1'b0;
      osc_range_code   <= 3'h0;
      clock_output_pin <= 1'b0;
      clock_output_oe  <= 1'b0;
    end else if (ce) begin
      cpu_run      <= st_d[3];
      loop_run     <= lp_en_q & ~st_d[4];
      loop_ref_sel <= lp_ref_q;
      loop_factor  <= mul_q;
      rc_osc_run   <= ~st_d[4] &
                      ((~is_osc && src_q != `OPS_SRC_WDOSC &&
                        src_q != `OPS_SRC_LOOP_XT &&
                        src_q != `OPS_SRC_LOOP_EC) ||
                       (lp_en_q && lp_ref_q == `OPS_REF_RC));
      osc_amp_en   <= ~st_d[4] &
                      (is_osc || src_q == `OPS_SRC_LOOP_XT ||
                       (lp_en_q && lp_ref_q == `OPS_REF_XTAL));
      osc_range_code <= is_osc ? src_q[3:1] : 3'h0;
      clock_output_oe <= ~st_q[0] & (nvco_q | clock_out_enable_bit_q);
      clock_output_pin <= ~st_q[0] & (nvco_q | clock_out_enable_bit_q) &
                          presc_clk_in;
    end
  end

endmodule

// ===== design/ops_defines.vh
`ifndef OPS_DEFINES_VH
`define OPS_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets (4-bit address, 8-bit data)
// ----------------------------------------------------------------------
`define OPS_ADDR_CSR     4'h0
`define OPS_ADDR_LCR     4'h1
`define OPS_ADDR_MUL     4'h2
`define OPS_ADDR_STAT    4'h3
`define OPS_ADDR_MASK    4'h4
`define OPS_ADDR_STATE   4'h5

// ----------------------------------------------------------------------
// clock selection register fields
// ----------------------------------------------------------------------
`define OPS_CSR_SRC_LSB  0
`define OPS_CSR_SRC_MSB  3
`define OPS_CSR_SUT_LSB  4
`define OPS_CSR_SUT_MSB  5
`define OPS_CSR_CLOCK_OUT_ENABLE_BIT     6

// ----------------------------------------------------------------------
// loop control register fields
// ----------------------------------------------------------------------
`define OPS_LCR_LOCK     0
`define OPS_LCR_EN       1
`define OPS_LCR_REF_LSB  2
`define OPS_LCR_REF_MSB  3

// ----------------------------------------------------------------------
// status / mask bit positions
// ----------------------------------------------------------------------
`define OPS_ST_RSTDONE   0
`define OPS_ST_WAKEDONE  1
`define OPS_ST_LOCKUP    2
`define OPS_ST_LOCKLOST  3

// ----------------------------------------------------------------------
// source codes and loop reference codes
// ----------------------------------------------------------------------
`define OPS_SRC_EXTCLK   4'h0
`define OPS_SRC_LOOP_RC  4'h1
`define OPS_SRC_RC8      4'h2
`define OPS_SRC_WDOSC    4'h3
`define OPS_SRC_LOOP_XT  4'h4
`define OPS_SRC_LOOP_EC  4'h5
`define OPS_SRC_RC1      4'h6
`define OPS_REF_RC       2'h0
`define OPS_REF_XTAL     2'h1
`define OPS_REF_EXTCLK   2'h2

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define OPS_MUL_RST      4'h0
`define OPS_MUL_INIT     4'h6
`define OPS_CNT_RST_CK   15'h000E
`define OPS_CNT_6CK      15'h0006
`define OPS_CNT_258CK    15'h0102
`define OPS_CNT_1KCK     15'h0400
`define OPS_CNT_16KCK    15'h4000
`define OPS_WDT_NONE     14'h0000
`define OPS_WDT_SHORT    14'h0200
`define OPS_WDT_LONG     14'h2000

`endif

// ===== design/ops_tick_counter.v
`timescale 1ns/1ps
`include "ops_defines.vh"

// ----------------------------------------------------------------------
// down counter of qualified ticks, one-cycle done pulse at zero
// ----------------------------------------------------------------------
module ops_tick_counter #(
  parameter W = 15
) (
  input  wire         clk,    // system clock
  input  wire         rst,    // async reset, high
  input  wire         ce,     // clock enable
  input  wire         start,  // load target, begin counting
  input  wire         tick,   // one counted cycle
  input  wire [W-1:0] target, // ticks to count
  output reg          busy,   // counting in progress
  output reg          done    // pulse when count ends
);

  reg [W-1:0] cnt_q; // remaining ticks

  // load, count down, flag completion
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= target;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q == {W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (tick) begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ===== tb/ops_clk_ctrl_props.sv
`timescale 1ns/1ps
module ops_clk_chk #(
  parameter [13:0] WDT_LONG = 14'h2000, // long reset delay
  parameter [14:0] CNT_16K  = 15'h4000  // long start-up count
) (
  input wire       clk,              // clock
  input wire       rst,              // async reset
  input wire       rd,               // read strobe
  input wire [7:0] rdata,            // read data
  input wire       src_tick,         // source cycle
  input wire       wdt_tick,         // watchdog cycle
  input wire       sleep_deep,       // deep sleep
  input wire       presc_clk_in,     // prescaled clock
  input wire       cpu_run,          // execution allowed
  input wire       rc_osc_run,       // rc enable
  input wire       loop_run,         // loop enable
  input wire [1:0] loop_ref_sel,     // loop reference
  input wire [2:0] osc_range_code,   // amplifier mode
  input wire       clock_output_pin, // clock out level
  input wire       clock_output_oe   // clock out drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // helper: source cycles seen while halted, saturating
  // ---------------------------------------------------------------
  reg [3:0] tk_q; // tick count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tk_q <= 4'h0;
    end else if (cpu_run) begin
      tk_q <= 4'h0;
    end else if (src_tick && tk_q != 4'hF) begin
      tk_q <= tk_q + 4'h1;
    end
  end

  sequence s_halt_quiet;
    (!cpu_run && !src_tick && !wdt_tick)[*6];
  endsequence
  sequence s_out_off;
    (!clock_output_oe && !clock_output_pin)[*2];
  endsequence

  property p_no_free_start;
    s_halt_quiet |=> !cpu_run;
  endproperty
  a_no_free_start: assert property (p_no_free_start)
    else $error("cpu started with no counted cycles");
  property p_wake_ticks;
    $rose(cpu_run) |-> tk_q >= 4'h6;
  endproperty
  a_wake_ticks: assert property (p_wake_ticks)
    else $error("cpu started after too few source cycles");
  property p_sleep_stops;
    sleep_deep && cpu_run |=> !cpu_run && !loop_run && !rc_osc_run;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops)
    else $error("rc or loop still running in deep sleep");
  property p_out_quiet;
    $fell(rst) |-> s_out_off;
  endproperty
  a_out_quiet: assert property (p_out_quiet)
    else $error("clock output active around reset");
  property p_pin_gated;
    !clock_output_oe |-> !clock_output_pin;
  endproperty
  a_pin_gated: assert property (p_pin_gated)
    else $error("clock pin moves while not driven");
  property p_pin_follow;
    $past(clock_output_oe) && clock_output_oe
      |-> clock_output_pin == $past(presc_clk_in);
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("clock pin is not the prescaled clock");
  property p_range;
    osc_range_code != 3'h0 |-> osc_range_code[2];
  endproperty
  a_range: assert property (p_range)
    else $error("illegal amplifier mode");
  property p_ref_legal;
    loop_ref_sel != 2'h3;
  endproperty
  a_ref_legal: assert property (p_ref_legal)
    else $error("loop reference outside the three sources");
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");
endmodule

bind ops_clk_ctrl ops_clk_chk #(.WDT_LONG(WDT_LONG), .CNT_16K(CNT_16K))
  u_chk (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
    .src_tick(src_tick), .wdt_tick(wdt_tick), .sleep_deep(sleep_deep),
    .presc_clk_in(presc_clk_in), .cpu_run(cpu_run),
    .rc_osc_run(rc_osc_run), .loop_run(loop_run),
    .loop_ref_sel(loop_ref_sel), .osc_range_code(osc_range_code),
    .clock_output_pin(clock_output_pin),
    .clock_output_oe(clock_output_oe));

// ===== tb/ops_src_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far side: resonator cycles, watchdog cycles, lock detect
// ---------------------------------------------------------------
// a ceramic resonator is fitted, so the lowest range code and the
// short 258-cycle start-up codes are fair choices here
module ops_src_model (
  input  wire  clk,         // system clock
  input  wire  rst,         // async reset, high
  input  wire  loop_run,    // loop enable from block
  output logic src_tick,    // one source cycle
  output logic wdt_tick,    // one watchdog cycle
  output logic loop_lock_in // lock detect level
);
  int lock_dly = 5; // cycles to lock, bench may slow it
  int lk;           // cycles since loop enable

  initial begin
    src_tick = 1'b0;
    wdt_tick = 1'b0;
  end

  // lock rises lock_dly+1 cycles after enable, drops at once
  always @(posedge clk or posedge rst) begin
    if (rst || !loop_run) begin
      lk <= 0;
      loop_lock_in <= 1'b0;
    end else if (lk >= lock_dly) begin
      loop_lock_in <= 1'b1;
    end else begin
      lk <= lk + 1;
    end
  end

  // n back-to-back cycles of the source (w=0) or watchdog (w=1)
  task automatic burst(input bit w, input int n);
    repeat (n) begin
      @(posedge clk);
      if (w) wdt_tick <= 1'b1;
      else src_tick <= 1'b1;
    end
    @(posedge clk);
    src_tick <= 1'b0;
    wdt_tick <= 1'b0;
  endtask
endmodule

// ===== tb/osc_pll_startup_clock_select_tb_top.sv
`timescale 1ns/1ps
`include "ops_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module osc_pll_startup_clock_select_tb_top;
  localparam int WL  = 32'h0000_0020; // shortened long delay
  localparam int C16 = 32'h0000_0028; // shortened long count
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  logic [3:0] addr = 4'h0, nv_src = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] nv_sut = 2'h0, ref_sel;
  logic nv_co = 1'b0, sleep_deep = 1'b0, presc = 1'b0, presc_q = 1'b0;
  logic src_tick, wdt_tick, lock, cpu_run, rc_run, loop_run, irq;
  logic co_pin, co_oe, amp;
  logic [3:0] factor, rv;
  logic [2:0] range;
  logic [16:0] lf = 17'h1_445A; // random source state
  logic [5:0] wq[$] = '{6'h08, 6'h09, 6'h19, 6'h3F, 6'h00, 6'h04,
                        6'h34, 6'h25, 6'h11}; // wake cases {sut,src}
  int fails = 0, cmp_count = 0;

  always #50 clk = ~clk;

  ops_clk_ctrl #(.WDT_LONG(14'h0020), .CNT_16K(15'h0028)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .nv_source_select(nv_src),
    .nv_startup_code(nv_sut), .nv_clock_out_option(nv_co),
    .src_tick(src_tick), .wdt_tick(wdt_tick), .sleep_deep(sleep_deep),
    .loop_lock_in(lock), .presc_clk_in(presc), .cpu_run(cpu_run),
    .rc_osc_run(rc_run), .loop_run(loop_run), .loop_ref_sel(ref_sel),
    .loop_factor(factor), .osc_amp_en(amp), .osc_range_code(range),
    .clock_output_pin(co_pin), .clock_output_oe(co_oe), .irq(irq));
  ops_src_model u_src (.clk(clk), .rst(rst), .loop_run(loop_run),
    .src_tick(src_tick), .wdt_tick(wdt_tick), .loop_lock_in(lock));

  // ---------------------------------------------------------------
  // model: start-up counts per source and start-up code
  // ---------------------------------------------------------------
  function automatic int wake_cnt(input int s, input int u);
    int k;
    k = (s % 2) * 4 + u;
    if (s >= 8) return (k < 2) ? 258 : (k < 5) ? 1024 : C16;
    if (s == 5 || (s == 4 && u == 3)) return C16;
    return (s == 4 || s == 1) ? 1024 : 6;
  endfunction
  function automatic int wdt_cnt(input int s, input int u);
    int k;
    k = (s % 2) * 4 + u;
    if (s >= 8) return (k % 3 == 2) ? 0 : (k % 3 == 0) ? 512 : WL;
    if (s == 5) return (u == 0) ? 0 : (u == 3) ? WL : 512;
    if (s == 4 && u == 3) return 0;
    return (u == 0) ? 0 : (u == 1) ? 512 : WL;
  endfunction
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction

  // random prescaled clock, and the value the pin should copy
  always @(posedge clk) begin
    lf <= lfsr(lf);
    presc <= lf[0];
    presc_q <= presc;
  end

  // ---------------------------------------------------------------
  // bus and timing tasks
  // ---------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // reset with given config, then feed each reset delay part one tick short, check halt, then the last tick
  task automatic boot(input logic [3:0] s, input logic [1:0] u,
                      input logic co);
    int w;
    w = wdt_cnt(s, u);
    @(posedge clk);
    rst <= 1'b1;
    nv_src <= s;
    nv_sut <= u;
    nv_co <= co;
    settle(6);
    `CHK(co_oe, 1'b0)
    @(posedge clk) rst <= 1'b0;
    settle(3);
    u_src.burst(0, 13);
    settle(6);
    `CHK(cpu_run, 1'b0)
    u_src.burst(0, 1);
    settle(4);
    if (w > 0) begin
      u_src.burst(1, w - 1);
      settle(6);
      `CHK(cpu_run, 1'b0)
      u_src.burst(1, 1);
    end
    settle(4);
    `CHK(cpu_run, 1'b1)
  endtask
  // select source by register, sleep, then wake on exact count
  task automatic wake(input logic [3:0] s, input logic [1:0] u);
    int n;
    n = wake_cnt(s, u);
    wreg(`OPS_ADDR_CSR, {2'b00, u, s});
    settle(2);
    `CHK(range, s[3] ? s[3:1] : 3'h0)
    @(posedge clk) sleep_deep <= 1'b1;
    settle(2);
    `CHK({cpu_run, loop_run, rc_run, amp}, 4'h0)
    @(posedge clk) sleep_deep <= 1'b0;
    settle(3);
    u_src.burst(0, n - 1);
    settle(6);
    `CHK(cpu_run, 1'b0)
    u_src.burst(0, 1);
    settle(4);
    `CHK(cpu_run, 1'b1)
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    boot(4'h5, 2'h1, 1'b1);
    settle(8);
    rchk(`OPS_ADDR_MUL, 8'h06);
    rchk(`OPS_ADDR_LCR, 8'h0B);
    `CHK({loop_run, ref_sel}, 3'h6)
    rchk(`OPS_ADDR_CSR, 8'h55);
    `CHK({co_oe, co_pin}, {1'b1, presc_q})
    rchk(`OPS_ADDR_STAT, 8'h05);
    wreg(`OPS_ADDR_MASK, 8'h01);
    settle(1);
    `CHK(irq, 1'b1)
    wreg(`OPS_ADDR_STAT, 8'h01);
    settle(1);
    `CHK(irq, 1'b0)
    wreg(`OPS_ADDR_MASK, 8'h04);
    settle(1);
    `CHK(irq, 1'b1)
    wreg(`OPS_ADDR_LCR, 8'h0C);
    settle(2);
    `CHK(loop_run, 1'b0)
    rchk(`OPS_ADDR_STAT, 8'h0C);
    rchk(`OPS_ADDR_LCR, 8'h08);
    wreg(`OPS_ADDR_STAT, 8'hFF);
    wreg(`OPS_ADDR_MASK, 8'h00);
    settle(1);
    `CHK(irq, 1'b0)
    u_src.lock_dly = 40;
    wreg(`OPS_ADDR_LCR, 8'h06);
    rchk(`OPS_ADDR_LCR, 8'h06);
    settle(45);
    rchk(`OPS_ADDR_LCR, 8'h07);
    rv = lf[3:0];
    wreg(`OPS_ADDR_MUL, {4'h0, rv});
    rchk(`OPS_ADDR_MUL, {4'h0, rv});
    `CHK(factor, rv)
    rchk(4'hF, 8'h00);
    foreach (wq[i]) wake(wq[i][3:0], wq[i][5:4]);
    rchk(`OPS_ADDR_STAT, 8'h0E);
    boot(4'hF, 2'h3, 1'b0);
    `CHK({range, factor, co_oe, amp}, {3'h7, 4'h0, 2'b01})
    @(posedge clk) ce <= 1'b0;
    wreg(`OPS_ADDR_MASK, 8'h0F);
    @(posedge clk) ce <= 1'b1;
    rchk(`OPS_ADDR_MASK, 8'h00);
    wreg(`OPS_ADDR_CSR, 8'h7F);
    settle(2);
    `CHK(co_oe, 1'b1)
    tally_and_finish;
  end

  // hang guard, far beyond the expected run
  initial begin
    #5_000_000;
    fails++;
    tally_and_finish;
  end
endmodule
